/* verilog/sarpr_pkg.sv */
// Overview of operation
// - Falling convert_start_n with chip select low and a free buffer entry switches the sampler from sample to hold and starts conversion.
// - Busy rises as conversion starts and stays high throughout it.
// - Busy falls as the finished result is captured into the two-entry result buffer.
// - Byte select low presents all sixteen result bits on result_bus.
// - Byte select high places result bits 15..8 on the low lines.
// - Byte select may toggle while the read strobe stays asserted.
// - Conversion steps only on the externally supplied conversion clock.
// - Conversion begins at first rising clock edge; seventeen edges complete it.
// - Further convert_start_n pulses are ignored until the conversion finishes.
// - Result lines stay undriven unless read strobe and chip select are low.
// - Result is two's complement, midscale zero, negative full scale most negative.
package sarpr_pkg;

    typedef enum logic [2:0] {
        SARPR_IDLE  = 3'b001,
        SARPR_ARMED = 3'b010,
        SARPR_CONV  = 3'b100
    } sarpr_state_t;

    localparam int          SARPR_WIDTH      = 16;
    localparam logic [4:0]  SARPR_STEP_FIRST = 5'h01;
    localparam logic [4:0]  SARPR_LATCH_EDGE = 5'h11;
    localparam logic [15:0] SARPR_TRIAL_MSB  = 16'h8000;
    localparam logic [15:0] SARPR_RST_WORD   = 16'h0000;
    localparam logic [4:0]  SARPR_RST_STEP   = 5'h00;
    localparam logic [1:0]  SARPR_BUF_DEPTH  = 2'h2;

endpackage : sarpr_pkg

/* verilog/sarpr_top.sv */
`timescale 1ns/1ps
module sarpr_top (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        conv_clk,
    input  wire logic        convert_start_n,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        byte_sel,
    input  wire logic        cmp_above,
    output logic      [15:0] dac_code,
    output logic             hold,
    output logic             busy,
    output logic      [15:0] result_bus,
    output logic      [15:0] result_bus_oe_n
);

    sarpr_pkg::sarpr_state_t state;
    sarpr_pkg::sarpr_state_t next_state;

    logic        conv_clk_q;
    logic        start_n_q;
    logic        rd_act_q;
    logic [15:0] sar;
    logic [15:0] mask;
    logic [4:0]  step;
    logic [15:0] buf_mem [2];
    logic        wr_ptr;
    logic        rd_ptr;
    logic [1:0]  buf_count;

    // State decodes shared by the datapath and the checks
    function automatic logic sarpr_is_conv(input sarpr_pkg::sarpr_state_t s);
        return s == sarpr_pkg::SARPR_CONV;
    endfunction : sarpr_is_conv

    // The first conversion edge already decides bit 15, so armed counts as active
    function automatic logic sarpr_is_active(input sarpr_pkg::sarpr_state_t s);
        return (s == sarpr_pkg::SARPR_ARMED) || (s == sarpr_pkg::SARPR_CONV);
    endfunction : sarpr_is_active

    wire conv_edge    = conv_clk & ~conv_clk_q;
    wire start_fall   = start_n_q & ~convert_start_n;
    wire buf_in_ready = (buf_count != sarpr_pkg::SARPR_BUF_DEPTH);
    // A full buffer refuses new starts so no unread word is overwritten
    wire start_req    = start_fall & ~cs_n & (state == sarpr_pkg::SARPR_IDLE) & buf_in_ready;
    wire in_conv      = sarpr_is_conv(state);
    wire in_active    = sarpr_is_active(state);
    // Edges one to sixteen decide bits; edge seventeen only moves the finished word
    wire latch        = in_conv & conv_edge & (step == sarpr_pkg::SARPR_LATCH_EDGE);
    wire resolve      = in_active & conv_edge & ~latch;
    wire [15:0] kept  = cmp_above ? sar : (sar & ~mask);
    wire [15:0] buf_in_data = {~kept[15], kept[14:0]};
    wire buf_in_valid = latch;
    wire buf_out_valid = (buf_count != 2'h0);
    wire rd_act       = ~rd_n & ~cs_n;
    wire buf_out_ready = rd_act_q & ~rd_act;
    wire push         = buf_in_valid & buf_in_ready;
    wire pop          = buf_out_valid & buf_out_ready;
    wire [15:0] head  = buf_mem[rd_ptr];
    wire [15:0] bus_word = byte_sel ? {head[15:8], head[15:8]} : head;

    always_comb begin
        next_state = state;
        case (state)
            sarpr_pkg::SARPR_IDLE:  if (start_req) next_state = sarpr_pkg::SARPR_ARMED;
            // Armed waits for the first conversion edge
            sarpr_pkg::SARPR_ARMED: if (conv_edge) next_state = sarpr_pkg::SARPR_CONV;
            sarpr_pkg::SARPR_CONV:  if (latch) next_state = sarpr_pkg::SARPR_IDLE;
            default:                next_state = sarpr_pkg::SARPR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state      <= sarpr_pkg::SARPR_IDLE;
            conv_clk_q <= 1'b0;
            start_n_q  <= 1'b1;
            rd_act_q   <= 1'b0;
        end else begin
            state      <= next_state;
            conv_clk_q <= conv_clk;
            start_n_q  <= convert_start_n;
            rd_act_q   <= rd_act;
        end
    end

    // Busy and hold follow the start and the result capture
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            hold <= 1'b0;
        end else if (start_req) begin
            busy <= 1'b1;
            hold <= 1'b1;
        end else if (latch) begin
            busy <= 1'b0;
            hold <= 1'b0;
        end
    end

    // Successive approximation, one bit per conversion clock edge on edges one to sixteen
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sar  <= sarpr_pkg::SARPR_RST_WORD;
            mask <= sarpr_pkg::SARPR_RST_WORD;
            step <= sarpr_pkg::SARPR_RST_STEP;
        end else if (start_req) begin
            sar  <= sarpr_pkg::SARPR_TRIAL_MSB;
            mask <= sarpr_pkg::SARPR_TRIAL_MSB;
            // Step holds the number of the coming conversion edge
            step <= sarpr_pkg::SARPR_STEP_FIRST;
        end else if (resolve) begin
            sar  <= kept | (mask >> 1);
            mask <= mask >> 1;
            step <= step + 5'h01;
        end
    end

    assign dac_code = sar;

    // Two-entry result buffer between converter and output bus
    // A read pops only as it ends, so a long strobe shows one word
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr    <= 1'b0;
            rd_ptr    <= 1'b0;
            buf_count <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            buf_count <= buf_count + {1'b0, push} - {1'b0, pop};
        end
    end

    // Data only, no reset needed
    always_ff @(posedge clk_sys) begin
        if (push) buf_mem[wr_ptr] <= buf_in_data;
    end

    // Registered bus; byte select is resampled every cycle during a read
    // Costs one cycle of byte-select lag but keeps the lines glitch free
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            result_bus      <= sarpr_pkg::SARPR_RST_WORD;
            result_bus_oe_n <= 16'hffff;
        end else begin
            result_bus      <= bus_word;
            result_bus_oe_n <= {16{~rd_act}};
        end
    end

    // Helper for the edge count check
    logic [4:0] hlp_edges;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) hlp_edges <= 5'h00;
        else if (start_req) hlp_edges <= 5'h00;
        else if (busy && conv_edge) hlp_edges <= hlp_edges + 5'h01;
    end

    // All checks sleep while reset is applied
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_busy_start: assert property (start_req |=> busy && hold ##1 busy)
        else $error("busy not raised on start");
    chk_hold_start: assert property (start_req |=> hold throughout (busy [*2]))
        else $error("sampler not in hold during conversion");
    chk_edge_count: assert property ($fell(busy) |-> hlp_edges == sarpr_pkg::SARPR_LATCH_EDGE)
        else $error("conversion did not take seventeen edges");
    chk_busy_result: assert property ($fell(busy) |-> buf_out_valid)
        else $error("busy fell without captured result");
    chk_no_restart: assert property (busy && start_fall && !latch |=> $stable(mask) || $past(resolve))
        else $error("restart during conversion");
    chk_clock_only: assert property (state == sarpr_pkg::SARPR_CONV && !conv_edge |=> $stable(sar))
        else $error("conversion stepped without clock edge");
    chk_full_word: assert property ($past(rd_act) && !$past(byte_sel) && !pop |-> result_bus == $past(head))
        else $error("full word not presented");
    chk_upper_byte: assert property ($past(byte_sel) |-> result_bus[7:0] == $past(head[15:8]))
        else $error("upper byte not on low lines");
    chk_bus_float: assert property (!rd_act |=> result_bus_oe_n == 16'hffff)
        else $error("bus driven outside read");
    chk_twos_comp: assert property (push |=> buf_mem[$past(wr_ptr)][15] == ~$past(kept[15]))
        else $error("result not two's complement");

    // Sequencing checks
    chk_first_edge: assert property (in_active && !in_conv && conv_edge |=> mask[14] && $onehot(mask))
        else $error("first conversion edge did not decide the top bit");
    chk_armed_wait: assert property (in_active && !in_conv && !conv_edge |=> in_active && !in_conv)
        else $error("conversion began without a clock edge");
    chk_step_bound: assert property (in_active |-> step <= sarpr_pkg::SARPR_LATCH_EDGE && |step)
        else $error("edge count out of range");
    chk_conv_steps: assert property (resolve |=> step == $past(step) + 5'h01)
        else $error("edge count did not advance");
    chk_bit_decide: assert property (resolve && !cmp_above |=> (sar & $past(mask)) == 16'h0000)
        else $error("rejected trial bit kept");
    chk_bit_keep: assert property (resolve && cmp_above |=> (sar & $past(mask)) == $past(mask))
        else $error("accepted trial bit dropped");
    chk_no_early_latch: assert property (in_conv && conv_edge && !latch |=> busy)
        else $error("busy fell before the last edge");
    chk_busy_state: assert property (busy == in_active)
        else $error("busy does not match conversion state");
    chk_hold_busy: assert property (hold == busy)
        else $error("hold does not span the conversion");
    chk_hold_release: assert property (latch |=> !busy && !hold)
        else $error("busy not released after capture");
    chk_latch_idle: assert property (latch |=> !in_active)
        else $error("converter not idle after capture");
    chk_idle_stable: assert property (!in_active && !start_req |=> $stable(sar) && $stable(mask))
        else $error("idle converter changed its trial word");
    chk_msb_trial: assert property (start_req |=> dac_code == sarpr_pkg::SARPR_TRIAL_MSB)
        else $error("conversion did not start from the top bit");
    chk_cs_refuse: assert property (start_fall && cs_n && !busy |=> !busy)
        else $error("start accepted without chip select");

    // Output bus and result buffer checks
    chk_oe_uniform: assert property (result_bus_oe_n == 16'h0000 || result_bus_oe_n == 16'hffff)
        else $error("output enables disagree");
    chk_read_drive: assert property (rd_act |=> result_bus_oe_n == 16'h0000)
        else $error("bus not driven during read");
    chk_upper_lines: assert property ($past(byte_sel) |-> result_bus[15:8] == $past(head[15:8]))
        else $error("upper lines lost the upper byte");
    chk_buf_bound: assert property (buf_count <= sarpr_pkg::SARPR_BUF_DEPTH)
        else $error("result buffer overfilled");

endmodule : sarpr_top

/* tb/sarpr_analog_model.sv */
`timescale 1ns/1ps
// Comparator stand-in: analog level given as an offset-binary code
module sarpr_analog_model (
    input  wire logic [15:0] dac_code,
    input  wire logic [15:0] level,
    output logic             cmp_above
);
    // At or above the trial code keeps the trial bit
    assign cmp_above = (level >= dac_code);
endmodule : sarpr_analog_model

/* tb/sarpr_top_test.sv */
`timescale 1ns/1ps
module sarpr_top_test;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        conv_clk = 1'b0;
    logic        convert_start_n = 1'b1;
    logic        cs_n = 1'b1;
    logic        rd_n = 1'b1;
    logic        byte_sel = 1'b0;
    logic        cmp_above;
    logic        hold;
    logic        busy;
    logic [15:0] dac_code;
    logic [15:0] result_bus;
    logic [15:0] result_bus_oe_n;
    logic [15:0] level = 16'h0000;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;
    sarpr_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .conv_clk(conv_clk),
        .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n), .byte_sel(byte_sel),
        .cmp_above(cmp_above), .dac_code(dac_code), .hold(hold), .busy(busy),
        .result_bus(result_bus), .result_bus_oe_n(result_bus_oe_n));
    sarpr_analog_model adc (.dac_code(dac_code), .level(level), .cmp_above(cmp_above));
    initial forever #20 clk_sys = ~clk_sys;
    task automatic complete_run;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        #1;
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    // Slow conversion clock, three system cycles per phase
    task automatic clk_edges(input int n);
        repeat (n) begin
            tick(3);
            conv_clk <= 1'b1;
            tick(3);
            conv_clk <= 1'b0;
        end
    endtask : clk_edges
    task automatic start(input logic cs);
        tick(1);
        cs_n <= cs;
        tick(1);
        convert_start_n <= 1'b0;
        tick(2);
        convert_start_n <= 1'b1;
        tick(1);
    endtask : start
    task automatic conv(input logic [15:0] lvl, input logic poke);
        level <= lvl;
        start(1'b0);
        check(16'(busy), 16'h0001);
        check(16'(hold), 16'h0001);
        if (poke) start(1'b0);
        clk_edges(16);
        check(16'(busy), 16'h0001);
        clk_edges(1);
        check(16'(busy), 16'h0000);
        check(16'(hold), 16'h0000);
        clk_edges(2);
        check(16'(busy), 16'h0000);
    endtask : conv
    task automatic read(input logic [15:0] exp);
        check(result_bus_oe_n, 16'hffff);
        rd_n <= 1'b0;
        tick(2);
        check(result_bus_oe_n, 16'h0000);
        check(result_bus, exp);
        byte_sel <= 1'b1;
        tick(2);
        check({8'h00, result_bus[7:0]}, {8'h00, exp[15:8]});
        byte_sel <= 1'b0;
        rd_n <= 1'b1;
        tick(2);
        check(result_bus_oe_n, 16'hffff);
    endtask : read
    task automatic code_test;
        logic [15:0] lv [4] = '{16'h8000, 16'h0000, 16'hffff, 16'h7fff};
        logic [15:0] ex [4] = '{16'h0000, 16'h8000, 16'h7fff, 16'hffff};
        for (int i = 0; i < 4; i++) begin
            conv(lv[i], i[0]);
            read(ex[i]);
        end
        $display("code test done");
    endtask : code_test
    task automatic refused_test;
        start(1'b1);
        check(16'(busy), 16'h0000);
        $display("refused test done");
    endtask : refused_test
    // Two unread words fill the buffer; a third start must be refused
    task automatic fill_test;
        conv(16'h1234, 1'b0);
        conv(16'h4321, 1'b0);
        start(1'b0);
        check(16'(busy), 16'h0000);
        read(16'h9234);
        read(16'hc321);
        $display("fill test done");
    endtask : fill_test
    initial begin
        tick(20);
        rst_n <= 1'b1;
        tick(2);
        check(result_bus_oe_n, 16'hffff);
        code_test();
        refused_test();
        fill_test();
        complete_run();
    end
endmodule : sarpr_top_test
